/* File: zme_top.sv */
// Zone monitor signal evaluator: per-group detection, exclusion, forcing.
// Assumes per-scan measurements arrive valid on scan_tick, one per group.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "zme_params.svh"
// Overview of operation
// - Width mode: wide target persisting asserts signals
// - Contour mode: deviation distance and length both over their limits, persisting, give alarm
// - Point/width give three signals; contour alarm only
// - Reset leaves every group in width mode
// - Learning allowed only in width mode
// - Learned matching targets suppress signal generation
// - Learning and exclusion enableable on active groups
// - Forcing inputs honoured only under tool selection
// - Disarm holds alarm inactive while high, unless forced alarm is also high
// - Forced alarm holds alarm active while high
// - Forcing leaves attention and pre-warning alone
// - Any signal change sends status message
module zme_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Scan timing and per-group measurements, area index 0 alarm 1 pre 2 attn
  input wire logic scan_tick,
  input wire logic [3*16*`ZME_NGROUP-1:0] point_count,
  input wire logic [3*16*`ZME_NGROUP-1:0] target_width,
  input wire logic [16*`ZME_NGROUP-1:0] contour_dev_dist,
  input wire logic [16*`ZME_NGROUP-1:0] contour_dev_len,
  input wire logic [`ZME_NGROUP-1:0] target_matches_db,
  input wire logic [`ZME_NGROUP-1:0] learn_done,
  // Forcing terminals
  input wire logic disarm_input,
  input wire logic force_alarm_input,
  // Monitoring outputs
  output logic alarm_out,
  output logic prewarn_out,
  output logic attention_out,
  output logic status_msg,
  output logic [5:0] status_bits,
  output logic [`ZME_NGROUP-1:0] learn_enable,
  output logic irq,
  // AXI4-Lite
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NG = `ZME_NGROUP;

  logic wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  logic toolsel_q;
  logic [5:0] stat_q;
  logic [5:0] mask_q;
  logic [5:0] cfg_q [NG];
  logic [31:0] thr_q [NG];
  logic [31:0] time_q [NG];
  logic [2:0] raw [NG];
  logic [2:0] det;
  logic alarm_d;
  logic [2:0] sig_d;
  logic [2:0] sig_q;
  logic [2:0] grp_sig_q;
  logic [5:0] ev;

  zme_axil u_bus (
    .clk(clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
    .wr_ok(wr_ok), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // Group register index from address, or NG when not a group address
  function automatic int grp_of(input logic [11:0] a);
    if (a >= `ZME_REG_GRP_CFG && a <= `ZME_REG_GRP_LAST && a[1:0] == 2'h0) begin
      return int'((a - `ZME_REG_GRP_CFG) / `ZME_REG_GRP_STRIDE);
    end
    return NG;
  endfunction

  function automatic logic [1:0] sub_of(input logic [11:0] a);
    logic [11:0] r;
    r = a - `ZME_REG_GRP_CFG;
    return r[3:2];
  endfunction

  function automatic logic [15:0] f16(input logic [31:0] w, input logic hi);
    return hi ? w[31:16] : w[15:0];
  endfunction

  // Write decode
  always_comb begin
    wr_ok = 1'b1;
    if (wr_addr == `ZME_REG_CTRL || wr_addr == `ZME_REG_MASK) begin
      wr_ok = 1'b1;
    end else if (wr_addr == `ZME_REG_STATUS || wr_addr == `ZME_REG_SIGNALS) begin
      wr_ok = 1'b1;
    end else if (grp_of(wr_addr) < NG && sub_of(wr_addr) != 2'h3) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      toolsel_q <= 1'b0;
      mask_q <= 6'h00;
    end else if (wr_en && wr_strb[0]) begin
      if (wr_addr == `ZME_REG_CTRL) begin
        toolsel_q <= wr_data[`ZME_CTRL_TOOLSEL];
      end else if (wr_addr == `ZME_REG_MASK) begin
        mask_q <= wr_data[5:0];
      end
    end
  end

  // Per-group configuration; mode defaults to target width
  always_ff @(posedge clk) begin
    for (int g = 0; g < NG; g++) begin
      if (reset) begin
        cfg_q[g] <= {3'h0, 1'b0, `ZME_MODE_RST};
        thr_q[g] <= {`ZME_CDIST_THR_RST, `ZME_WIDTH_THR_RST};
        time_q[g] <= {`ZME_CLEN_THR_RST, `ZME_TIME_RST};
      end else if (wr_en && grp_of(wr_addr) == g) begin
        if (sub_of(wr_addr) == 2'h0 && wr_strb[0]) begin
          cfg_q[g] <= wr_data[5:0];
        end else if (sub_of(wr_addr) == 2'h1) begin
          thr_q[g] <= wr_data;
        end else if (sub_of(wr_addr) == 2'h2) begin
          time_q[g] <= wr_data;
        end
      end
    end
  end

  // Learning permitted only on active width-mode groups
  always_ff @(posedge clk) begin
    for (int g = 0; g < NG; g++) begin
      if (reset) begin
        learn_enable[g] <= 1'b0;
      end else begin
        learn_enable[g] <= cfg_q[g][`ZME_CFG_LEARN] && cfg_q[g][`ZME_CFG_ACTIVE]
          && cfg_q[g][`ZME_CFG_MODE_LO +: 2] == zme_pkg::ZME_MODE_WIDTH;
      end
    end
  end

  // Per-group, per-area detection; thr low half is point or width limit
  genvar gi, ai;
  generate
    for (gi = 0; gi < NG; gi++) begin : g_grp
      logic excl;
      logic [1:0] md;
      assign md = cfg_q[gi][`ZME_CFG_MODE_LO +: 2];
      assign excl = cfg_q[gi][`ZME_CFG_EXCL] && learn_done[gi]
        && target_matches_db[gi];
      for (ai = 0; ai < 3; ai++) begin : g_area
        logic cond;
        logic lvl;
        logic [15:0] pc;
        logic [15:0] tw;
        assign pc = point_count[(gi*3+ai)*16 +: 16];
        assign tw = target_width[(gi*3+ai)*16 +: 16];
        always_comb begin
          cond = 1'b0;
          case (md)
            zme_pkg::ZME_MODE_POINT: cond = pc > thr_q[gi][15:0];
            zme_pkg::ZME_MODE_WIDTH: cond = tw > thr_q[gi][15:0];
            zme_pkg::ZME_MODE_CONTOUR: begin
              if (ai == 0) begin
                cond = contour_dev_dist[gi*16 +: 16] > f16(thr_q[gi], 1'b1)
                  && contour_dev_len[gi*16 +: 16] > f16(time_q[gi], 1'b1);
              end
            end
            default: cond = 1'b0;
          endcase
          cond = cond && cfg_q[gi][`ZME_CFG_ACTIVE] && !excl;
        end
        zme_persist u_p (
          .clk(clk), .reset(reset), .scan_tick(scan_tick), .cond(cond),
          .limit(time_q[gi][15:0]), .level(lvl)
        );
        assign raw[gi][ai] = lvl;
      end
    end
  endgenerate

  always_comb begin
    det = 3'h0;
    for (int g = 0; g < NG; g++) begin
      det = det | raw[g];
    end
  end

  // Forcing: only under tool selection; forced alarm beats disarm
  always_comb begin
    alarm_d = det[0];
    if (toolsel_q) begin
      if (force_alarm_input) begin
        alarm_d = 1'b1;
      end else if (disarm_input) begin
        alarm_d = 1'b0;
      end
    end
    sig_d = {det[2], det[1], alarm_d};
  end

  // Inputs are level sampled every clock, far faster than a scan cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      sig_q <= 3'h0;
      grp_sig_q <= 3'h0;
      alarm_out <= 1'b0;
      prewarn_out <= 1'b0;
      attention_out <= 1'b0;
      status_bits <= 6'h00;
    end else begin
      sig_q <= sig_d;
      grp_sig_q <= det;
      alarm_out <= sig_d[0];
      prewarn_out <= sig_d[1];
      attention_out <= sig_d[2];
      status_bits <= {sig_d[2], det[2], sig_d[1], det[1], sig_d[0], det[0]};
    end
  end

  // Status message pulse on any change, forced ones included
  always_ff @(posedge clk) begin
    if (reset) begin
      status_msg <= 1'b0;
    end else begin
      status_msg <= sig_d != sig_q;
    end
  end

  // Sticky events: bit 2n group, bit 2n+1 output rises/falls of alarm, prewarn, attention
  assign ev = {sig_d[2] ^ sig_q[2], det[2] ^ grp_sig_q[2],
               sig_d[1] ^ sig_q[1], det[1] ^ grp_sig_q[1],
               sig_d[0] ^ sig_q[0], det[0] ^ grp_sig_q[0]};

  always_ff @(posedge clk) begin
    if (reset) begin
      stat_q <= 6'h00;
    end else if (rd_en && rd_addr == `ZME_REG_STATUS) begin
      stat_q <= ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |((stat_q | ev) & mask_q);
    end
  end

  // Read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (rd_addr == `ZME_REG_CTRL) begin
      rd_data = {31'h0, toolsel_q};
    end else if (rd_addr == `ZME_REG_STATUS) begin
      rd_data = {26'h0, stat_q};
    end else if (rd_addr == `ZME_REG_MASK) begin
      rd_data = {26'h0, mask_q};
    end else if (rd_addr == `ZME_REG_SIGNALS) begin
      rd_data = {24'h0, disarm_input, force_alarm_input, status_bits};
    end else if (grp_of(rd_addr) < NG && sub_of(rd_addr) == 2'h0) begin
      rd_data = {26'h0, learn_done[grp_of(rd_addr)], cfg_q[grp_of(rd_addr)][4:0]};
    end else if (grp_of(rd_addr) < NG && sub_of(rd_addr) == 2'h1) begin
      rd_data = thr_q[grp_of(rd_addr)];
    end else if (grp_of(rd_addr) < NG && sub_of(rd_addr) == 2'h2) begin
      rd_data = time_q[grp_of(rd_addr)];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Learning gate watched on every group, not only the first
  a_force_wins: assert property (@(posedge clk) disable iff (reset)
    toolsel_q && force_alarm_input |=> alarm_out)
    else $error("alarm not forced");
  a_disarm_holds: assert property (@(posedge clk) disable iff (reset)
    toolsel_q && disarm_input && !force_alarm_input |=> !alarm_out)
    else $error("alarm not disarmed");
  a_both_high: assert property (@(posedge clk) disable iff (reset)
    toolsel_q && disarm_input && force_alarm_input |=> alarm_out)
    else $error("force did not win");
  a_io_ignored: assert property (@(posedge clk) disable iff (reset)
    !toolsel_q |=> alarm_out == $past(det[0]))
    else $error("forcing honoured under io selection");
  a_others_free: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> prewarn_out == $past(det[1]) && attention_out == $past(det[2]))
    else $error("forcing touched other signals");
  a_msg_change: assert property (@(posedge clk) disable iff (reset)
    $changed({alarm_out, prewarn_out, attention_out}) |-> status_msg)
    else $error("no status message on change");
  for (genvar lg = 0; lg < NG; lg++) begin : g_learn_chk
    a_learn_gate: assert property (@(posedge clk) disable iff (reset)
      learn_enable[lg] |-> $past(cfg_q[lg][`ZME_CFG_MODE_LO +: 2]) == zme_pkg::ZME_MODE_WIDTH)
      else $error("learning outside width mode");
  end
  a_mode_reset: assert property (@(posedge clk)
    $past(reset) && !reset |-> cfg_q[0][`ZME_CFG_MODE_LO +: 2] == zme_pkg::ZME_MODE_WIDTH)
    else $error("reset mode not width");
endmodule

/* File: zme_params.svh */
// Constants for the zone monitor signal evaluator.
// Assumes inclusion by every design file of the block.
`ifndef ZME_PARAMS_SVH
`define ZME_PARAMS_SVH
`define ZME_NGROUP 4
`define ZME_REG_CTRL 12'h000
`define ZME_REG_STATUS 12'h004
`define ZME_REG_MASK 12'h008
`define ZME_REG_SIGNALS 12'h00c
`define ZME_REG_GRP_CFG 12'h010
`define ZME_REG_GRP_THR 12'h014
`define ZME_REG_GRP_TIME 12'h018
`define ZME_REG_GRP_STRIDE 12'h010
`define ZME_REG_GRP_LAST 12'h04c
`define ZME_PT_THR_RST 16'h0006
`define ZME_WIDTH_THR_RST 16'h0006
`define ZME_CDIST_THR_RST 16'h0014
`define ZME_CLEN_THR_RST 16'h0006
`define ZME_TIME_RST 16'h0000
`define ZME_MODE_RST 2'h1
`define ZME_CTRL_TOOLSEL 0
`define ZME_CFG_MODE_LO 0
`define ZME_CFG_ACTIVE 2
`define ZME_CFG_LEARN 3
`define ZME_CFG_EXCL 4
`define ZME_CFG_LEARNED 5
`define ZME_AXI_OKAY 2'h0
`define ZME_AXI_SLVERR 2'h2
`endif

/* File: zme_pkg.sv */
// Types shared by the zone monitor signal evaluator.
// Assumes no other package.
package zme_pkg;
  typedef enum logic [1:0] {
    ZME_MODE_POINT = 2'h0,
    ZME_MODE_WIDTH = 2'h1,
    ZME_MODE_CONTOUR = 2'h2
  } zme_mode_t;
  typedef enum logic [2:0] {
    ZME_IDLE = 3'h1,
    ZME_WRESP = 3'h2,
    ZME_RDATA = 3'h4
  } zme_bus_st_t;
endpackage

/* File: zme_persist.sv */
// Persistence filter: level rises once cond has held beyond a scan count.
// Assumes scan_tick is a one-cycle pulse per scan cycle.
`timescale 1ns/1ps
`include "zme_params.svh"
module zme_persist (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Scan timing and condition
  input wire logic scan_tick,
  input wire logic cond,
  input wire logic [15:0] limit,
  // Result
  output logic level
);
  logic [15:0] cnt_q;

  // Strictly longer than limit: needs limit+1 consecutive true scans
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= `ZME_TIME_RST;
      level <= 1'b0;
    end else if (scan_tick) begin
      if (!cond) begin
        cnt_q <= `ZME_TIME_RST;
        level <= 1'b0;
      end else if (cnt_q >= limit) begin
        level <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  a_persist_drop: assert property (@(posedge clk) disable iff (reset)
    scan_tick && !cond |=> !level)
    else $error("persist level stayed after condition fell");
endmodule

/* File: zme_axil.sv */
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes a single clock and a synchronous reset.
`timescale 1ns/1ps
`include "zme_params.svh"
module zme_axil (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic wr_en,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [11:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_have_q;
  logic w_have_q;
  logic [11:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;

  assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_addr = aw_q;
  assign wr_data = wd_q;
  assign wr_strb = ws_q;
  assign rd_en = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  // Address and data accepted in either order
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 12'h000;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `ZME_AXI_OKAY : `ZME_AXI_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !rd_en;
      if (rd_en) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? `ZME_AXI_OKAY : `ZME_AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* File: zme_ext_model.sv */
// Partner model: external switches driving the disarm and forced-alarm terminals.
// Assumes the bench pulses scan_tick once per scan cycle.
`timescale 1ns/1ps
module zme_ext_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Requests from the bench
  input wire logic scan_tick,
  input wire logic want_disarm,
  input wire logic want_force,
  // Terminal levels
  output logic disarm_input,
  output logic force_alarm_input
);
  // Levels move only on a scan boundary, so each one holds for a whole scan
  always_ff @(posedge clk) begin
    if (reset) begin
      disarm_input <= 1'b0;
      force_alarm_input <= 1'b0;
    end else if (scan_tick) begin
      disarm_input <= want_disarm;
      force_alarm_input <= want_force;
    end
  end
endmodule

/* File: tb.sv */
// Self-checking bench for the zone monitor signal evaluator.
// Assumes zme_top, zme_ext_model and zme_params.svh are compiled alongside.
`timescale 1ns/1ps
`include "zme_params.svh"
module tb;
  typedef struct packed {
    logic [1:0] md;
    logic [2:0] am;
    logic [15:0] pt;
    logic [15:0] wd;
    logic [15:0] cd;
    logic [15:0] cl;
    logic [2:0] ex;
  } zme_row_t;
  logic clk, reset, scan_tick, want_disarm, want_force, disarm_input, force_alarm_input;
  logic [191:0] point_count, target_width;
  logic [63:0] contour_dev_dist, contour_dev_len;
  logic [3:0] target_matches_db, learn_done, learn_enable, s_axi_wstrb;
  logic alarm_out, prewarn_out, attention_out, status_msg, irq;
  logic [5:0] status_bits;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int num_errors, comparisons, cycles, msg_cnt, m0;
  zme_row_t rows [8];

  zme_top zme_top_i (
    .clk, .reset, .scan_tick, .point_count, .target_width, .contour_dev_dist,
    .contour_dev_len, .target_matches_db, .learn_done, .disarm_input, .force_alarm_input,
    .alarm_out, .prewarn_out, .attention_out, .status_msg, .status_bits, .learn_enable, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  zme_ext_model zme_ext_model_i (
    .clk, .reset, .scan_tick, .want_disarm, .want_force, .disarm_input, .force_alarm_input
  );

  always #2.5 clk = ~clk;

  // Whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (status_msg === 1'b1) msg_cnt++;
    if (cycles == 6000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Counts: %0d comparisons, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] outs();
    return {29'h0, attention_out, prewarn_out, alarm_out};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      aw_d = aw_d | (s_axi_awready === 1'b1);
      w_d = w_d | (s_axi_wready === 1'b1);
      s_axi_awvalid <= ~aw_d;
      s_axi_wvalid <= ~w_d;
      if (s_axi_bvalid === 1'b1) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a);
    logic ar_d;
    ar_d = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      ar_d = ar_d | (s_axi_arready === 1'b1);
      s_axi_arvalid <= ~ar_d;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Group 0 only; the other groups see no target
  task automatic meas(input logic [2:0] am, input logic [15:0] pt, wd, cd, cl);
    logic [191:0] p, w;
    p = '0;
    w = '0;
    for (int a = 0; a < 3; a++) begin
      if (am[a]) begin
        p[a*16 +: 16] = pt;
        w[a*16 +: 16] = wd;
      end
    end
    @(posedge clk);
    point_count <= p;
    target_width <= w;
    contour_dev_dist <= {48'h0, cd};
    contour_dev_len <= {48'h0, cl};
  endtask

  task automatic tick();
    @(posedge clk);
    scan_tick <= 1'b1;
    @(posedge clk);
    scan_tick <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic frc(input logic d, input logic f);
    @(posedge clk);
    want_disarm <= d;
    want_force <= f;
    tick();
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {scan_tick, want_disarm, want_force} = 3'h0;
    {point_count, target_width, contour_dev_dist, contour_dev_len} = '0;
    {target_matches_db, learn_done} = 8'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    rows = '{
      '{2'h0, 3'h1, 16'h0007, 16'h0000, 16'h0000, 16'h0000, 3'h1},
      '{2'h0, 3'h1, 16'h0006, 16'h0000, 16'h0000, 16'h0000, 3'h0},
      '{2'h0, 3'h4, 16'h0007, 16'h0000, 16'h0000, 16'h0000, 3'h4},
      '{2'h1, 3'h2, 16'h0000, 16'h0007, 16'h0000, 16'h0000, 3'h2},
      '{2'h1, 3'h2, 16'h0000, 16'h0006, 16'h0000, 16'h0000, 3'h0},
      '{2'h2, 3'h4, 16'h0000, 16'h0007, 16'h0015, 16'h0007, 3'h1},
      '{2'h2, 3'h4, 16'h0000, 16'h0007, 16'h0014, 16'h0007, 3'h0},
      '{2'h2, 3'h4, 16'h0000, 16'h0007, 16'h0015, 16'h0006, 3'h0}
    };
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    chk(outs(), 32'h0);
    for (int g = 0; g < 4; g++) begin
      rdr(`ZME_REG_GRP_CFG + 12'(g * 16));
      chk(rd, 32'h1);
    end
    rdr(`ZME_REG_GRP_THR);
    chk(rd, 32'h0014_0006);
    rdr(`ZME_REG_GRP_TIME);
    chk(rd, 32'h0006_0000);
    rdr(12'h100);
    chk({30'h0, rsp}, 32'h2);
    wr(12'h01c, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    $display("Test reset done");

    for (int i = 0; i < 8; i++) begin
      wr(`ZME_REG_GRP_CFG, {29'h0, 1'b1, rows[i].md});
      meas(rows[i].am, rows[i].pt, rows[i].wd, rows[i].cd, rows[i].cl);
      tick();
      chk(outs(), {29'h0, rows[i].ex});
      meas(3'h0, 16'h0, 16'h0, 16'h0, 16'h0);
      tick();
      $display("Test row %0d done", i);
    end

    // Persistence of two scans needs a third scan with the target present
    wr(`ZME_REG_GRP_TIME, 32'h0006_0002);
    wr(`ZME_REG_GRP_CFG, 32'h5);
    meas(3'h1, 16'h0, 16'h7, 16'h0, 16'h0);
    tick();
    tick();
    chk(outs(), 32'h0);
    tick();
    chk(outs(), 32'h1);
    wr(`ZME_REG_GRP_TIME, 32'h0006_0000);
    meas(3'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    tick();
    $display("Test persistence done");

    @(posedge clk);
    learn_done <= 4'h1;
    target_matches_db <= 4'h1;
    wr(`ZME_REG_GRP_CFG, 32'h15);
    rdr(`ZME_REG_GRP_CFG);
    chk(rd, 32'h35);
    meas(3'h1, 16'h0, 16'h7, 16'h0, 16'h0);
    tick();
    chk(outs(), 32'h0);
    @(posedge clk);
    target_matches_db <= 4'h0;
    tick();
    chk(outs(), 32'h1);
    meas(3'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    tick();
    wr(12'h040, 32'hd);
    repeat (3) @(posedge clk);
    chk({28'h0, learn_enable}, 32'h8);
    wr(12'h040, 32'hc);
    repeat (3) @(posedge clk);
    chk({28'h0, learn_enable}, 32'h0);
    $display("Test exclusion done");

    wr(`ZME_REG_GRP_CFG, 32'h5);
    frc(1'b0, 1'b1);
    chk(outs(), 32'h0);
    m0 = msg_cnt;
    wr(`ZME_REG_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk(outs(), 32'h1);
    chk({31'h0, msg_cnt != m0}, 32'h1);
    meas(3'h3, 16'h0, 16'h7, 16'h0, 16'h0);
    frc(1'b1, 1'b0);
    chk(outs(), 32'h2);
    chk({26'h0, status_bits}, 32'h0000_000d);
    rdr(`ZME_REG_SIGNALS);
    chk(rd, 32'h0000_008d);
    frc(1'b1, 1'b1);
    chk(outs(), 32'h3);
    m0 = msg_cnt;
    frc(1'b1, 1'b0);
    chk({31'h0, msg_cnt != m0}, 32'h1);
    frc(1'b0, 1'b0);
    chk(outs(), 32'h3);
    meas(3'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    tick();
    $display("Test forcing done");

    chk({31'h0, irq}, 32'h0);
    wr(`ZME_REG_MASK, 32'h3f);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rdr(`ZME_REG_STATUS);
    chk({31'h0, rd != 32'h0}, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("Test interrupt done");

    // Second reset in mid-run: mode and mask return to their reset values
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rdr(`ZME_REG_GRP_CFG);
    chk(rd, 32'h0000_0021);
    rdr(`ZME_REG_MASK);
    chk(rd, 32'h0);
    $display("Test second reset done");
    summarize();
  end
endmodule
